// ---- src/cpu_external_bus_interface.sv ----
// External bus master interface with an AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none
module cpu_external_bus_interface
    import ebi_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output var status_t bus_status_o,
    output logic address_strobe_o,
    output logic data_strobe_n_o,
    output logic ctl_oe_o,
    input wire logic address_ready_in_i,
    input wire logic data_ready_in_i,
    input wire logic [0:15] info_bus_i,
    output logic [0:15] info_bus_o,
    output logic info_bus_oe_o,
    output logic [3:0] processor_state_o,
    output logic [3:0] page_group_select_o,
    output logic bus_request_n_o,
    input wire logic bus_grant_n_i,
    input wire logic bus_busy_n_i,
    output logic bus_busy_n_o,
    output logic bus_busy_oe_o,
    input wire logic bus_hold_n_i,
    output logic bus_hold_n_o,
    output logic bus_hold_oe_o,
    input wire logic protect_fault_n_i,
    input wire logic parity_fault_n_i,
    input wire logic ext_addr_fault_n_i,
    output logic dma_en_o,
    output logic self_test_passed_o,
    output logic instr_start_flag_o,
    output logic trigger_pulse_n_o,
    output logic priv_ok_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sync_t s1, s2, s3, f;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1 <= SYNC_RST;
            s2 <= SYNC_RST;
            s3 <= SYNC_RST;
            f <= SYNC_RST;
        end else begin
            s1 <= {info_bus_i, ext_addr_fault_n_i, parity_fault_n_i, protect_fault_n_i,
                   data_ready_in_i, address_ready_in_i, bus_hold_n_i, bus_busy_n_i,
                   bus_grant_n_i};
            s2 <= s1;
            s3 <= s2;
            // A bit moves only once the two later stages agree
            f <= (s2 & s3) | (f & (s2 ^ s3));
        end
    end
    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_got, w_got, wr_en;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    state_t state;
    cyc_t cyc;
    logic [15:0] addr, wdata, rdata, flt;
    logic [3:0] key, page, trig_cnt;
    logic hold_act, own, drv, busy_prev, init_pend;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= OFF_DISC);
    endfunction : mapped

    function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
        mrg = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : mrg

    assign s_axi_awready_o = !aw_got && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_got && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign wr_en = aw_got && w_got;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (wr_en) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr_i)
            OFF_CTRL: rd_mux[4:0] = {cyc.lock, cyc.dat, cyc.mem, cyc.rd, 1'b0};
            OFF_ADDR: rd_mux[15:0] = addr;
            OFF_WDATA: rd_mux[15:0] = wdata;
            OFF_RDATA: rd_mux[15:0] = rdata;
            OFF_KEYS: rd_mux[7:0] = {page, key};
            OFF_STAT: rd_mux[4:0] = {self_test_passed_o, dma_en_o, hold_act, own,
                                     state != ST_IDLE};
            OFF_FAULT: rd_mux[15:0] = flt;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_mux;
            s_axi_rresp_o <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Cycle set-up registers
    // ------------------------------------------------------------
    logic idle_wr, go, disc_wr;
    assign idle_wr = wr_en && state == ST_IDLE;
    assign go = idle_wr && aw_addr == OFF_CTRL && w_strb[0] && w_data[CTRL_GO];
    assign disc_wr = wr_en && aw_addr == OFF_DISC && w_strb[0];

    // Set-up is frozen while a cycle runs so the pins never change mid-cycle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cyc <= '0;
            addr <= 16'h0000;
            wdata <= 16'h0000;
            key <= 4'h0;
            page <= 4'h0;
        end else begin
            if (idle_wr && aw_addr == OFF_CTRL && w_strb[0]) begin
                cyc <= {w_data[CTRL_DAT], w_data[CTRL_RD], w_data[CTRL_MEM], w_data[CTRL_LOCK]};
            end
            if (idle_wr && aw_addr == OFF_ADDR) begin
                addr <= mrg(addr, w_data, w_strb);
            end
            if (idle_wr && aw_addr == OFF_WDATA) begin
                wdata <= mrg(wdata, w_data, w_strb);
            end
            if (idle_wr && aw_addr == OFF_KEYS && w_strb[0]) begin
                key <= w_data[3:0];
                page <= w_data[7:4];
            end
        end
    end
    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    logic can_start;
    // Our own held lock does not block us; a foreign lock or busy does
    assign can_start = !f.gnt_n && (hold_act || (f.busy_n && f.hold_n));

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
            rdata <= 16'h0000;
        end else begin
            unique case (state)
                ST_IDLE: if (go) state <= ST_REQ;
                ST_REQ: if (can_start) state <= ST_ADDR;
                ST_ADDR: if (f.ardy) state <= ST_AHOLD;
                ST_AHOLD: state <= ST_DATA;
                ST_DATA: begin
                    if (f.drdy) begin
                        state <= ST_END;
                        if (cyc.rd) rdata <= f.info;
                    end
                end
                ST_END: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_act <= 1'b0;
        end else if (state == ST_REQ && can_start && cyc.lock) begin
            hold_act <= 1'b1;
        end else if (state == ST_END && !cyc.lock) begin
            hold_act <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic in_cyc;
    assign in_cyc = state == ST_ADDR || state == ST_AHOLD || state == ST_DATA;
    assign own = in_cyc || state == ST_END || hold_act;
    // Grant passes the synchroniser, so floating lags a grant loss by four clocks
    assign drv = own && !f.gnt_n;
    assign ctl_oe_o = drv;
    assign bus_busy_oe_o = drv;
    assign bus_hold_oe_o = drv;
    assign bus_request_n_o = state != ST_REQ;
    assign bus_status_o = {cyc.dat, cyc.rd, cyc.mem};
    assign address_strobe_o = state == ST_ADDR;
    assign data_strobe_n_o = state != ST_DATA;
    assign bus_busy_n_o = !in_cyc;
    assign bus_hold_n_o = hold_act ? 1'b0 : bus_busy_n_o;
    assign info_bus_oe_o = drv && (state == ST_ADDR || state == ST_AHOLD ||
                                   (state == ST_DATA && !cyc.rd));
    assign info_bus_o = (state == ST_DATA) ? wdata : addr;
    assign processor_state_o = key;
    assign page_group_select_o = page;
    assign priv_ok_o = key == 4'h0;
    // ------------------------------------------------------------
    // Fault capture
    // ------------------------------------------------------------
    logic own_end, for_end, busy_ours;
    logic [15:0] flt_set, flt_clr;
    assign own_end = state == ST_END;
    // Our own busy rise reaches the synchroniser late and must not count as foreign
    assign for_end = !own && !busy_ours && f.busy_n && !busy_prev;
    always_comb begin
        flt_set = 16'h0000;
        if (own_end) begin
            flt_set[FLT_PRT_OWN] = !f.prt_n;
            flt_set[FLT_PAR] = !f.par_n;
            flt_set[FLT_EXT_MEM] = !f.ext_n && cyc.mem;
            flt_set[FLT_EXT_IO] = !f.ext_n && !cyc.mem;
        end else if (for_end) begin
            flt_set[FLT_PRT_FOR] = !f.prt_n;
            flt_set[FLT_PAR] = !f.par_n;
        end
    end
    assign flt_clr = (wr_en && aw_addr == OFF_FAULT) ? mrg(16'h0000, w_data, w_strb) : 16'h0000;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flt <= 16'h0000;
            busy_prev <= 1'b1;
            busy_ours <= 1'b0;
        end else begin
            busy_prev <= f.busy_n;
            if (in_cyc) busy_ours <= 1'b1;
            else if (f.busy_n && !busy_prev) busy_ours <= 1'b0;
            // A new fault in the clearing cycle survives
            flt <= ((flt & ~flt_clr) | flt_set) & FLT_MASK;
        end
    end
    // ------------------------------------------------------------
    // Discrete outputs
    // ------------------------------------------------------------
    logic trig_hit;
    assign trig_hit = own_end && !cyc.mem && addr == TRIG_ADDR;
    assign trigger_pulse_n_o = trig_cnt == 4'h0;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dma_en_o <= 1'b0;
            self_test_passed_o <= 1'b0;
            instr_start_flag_o <= 1'b0;
        end else begin
            instr_start_flag_o <= disc_wr && w_data[DISC_ISTART];
            if (disc_wr && w_data[DISC_DMA_ON]) dma_en_o <= 1'b1;
            else if (disc_wr && w_data[DISC_DMA_OFF]) dma_en_o <= 1'b0;
            if (disc_wr && w_data[DISC_ST_OK]) self_test_passed_o <= 1'b1;
            else if (disc_wr && w_data[DISC_ST_CLR]) self_test_passed_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            init_pend <= 1'b1;
            trig_cnt <= 4'h0;
        end else begin
            init_pend <= 1'b0;
            if (init_pend || trig_hit) trig_cnt <= TRIG_CYC;
            else if (trig_cnt != 4'h0) trig_cnt <= trig_cnt - 4'h1;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_io_trig;
        own_end && !cyc.mem && addr == TRIG_ADDR;
    endsequence
    sequence s_addr_done;
        state == ST_ADDR && f.ardy;
    endsequence
    property p_status;
        in_cyc |-> bus_status_o == {cyc.dat, cyc.rd, cyc.mem};
    endproperty
    a_status: assert property (p_status) else $error("status lines wrong");
    property p_float;
        f.gnt_n |-> !ctl_oe_o && !info_bus_oe_o && !bus_busy_oe_o && !bus_hold_oe_o;
    endproperty
    a_float: assert property (p_float) else $error("driving without grant");
    property p_astb;
        s_addr_done |=> !address_strobe_o && info_bus_o == addr ##1 !data_strobe_n_o;
    endproperty
    a_astb: assert property (p_astb) else $error("strobe sequence wrong");
    property p_await;
        state == ST_ADDR && !f.ardy |=> address_strobe_o && !bus_busy_n_o;
    endproperty
    a_await: assert property (p_await) else $error("address wait lost");
    property p_dwait;
        state == ST_DATA && !f.drdy |=> !data_strobe_n_o;
    endproperty
    a_dwait: assert property (p_dwait) else $error("data wait lost");
    property p_req;
        state == ST_REQ && can_start |=> bus_request_n_o && address_strobe_o;
    endproperty
    a_req: assert property (p_req) else $error("request not released");
    property p_mimic;
        !hold_act |-> bus_hold_n_o == bus_busy_n_o;
    endproperty
    a_mimic: assert property (p_mimic) else $error("lock does not follow busy");
    property p_lock;
        hold_act && state == ST_END && cyc.lock |=> !bus_hold_n_o;
    endproperty
    a_lock: assert property (p_lock) else $error("lock dropped early");
    property p_trig;
        s_io_trig |=> !trigger_pulse_n_o [*2] ##1 trigger_pulse_n_o;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger pulse wrong");
    property p_prt;
        own_end && !f.prt_n |=> flt[FLT_PRT_OWN];
    endproperty
    a_prt: assert property (p_prt) else $error("protect fault lost");
    property p_ext;
        own_end && !f.ext_n && !cyc.mem |=> flt[FLT_EXT_IO];
    endproperty
    a_ext: assert property (p_ext) else $error("address fault lost");
    property p_dma;
        disc_wr && w_data[DISC_DMA_ON] |=> dma_en_o;
    endproperty
    a_dma: assert property (p_dma) else $error("dma enable missed");
    property p_priv;
        priv_ok_o == (processor_state_o == 4'h0);
    endproperty
    a_priv: assert property (p_priv) else $error("privilege flag wrong");
endmodule : cpu_external_bus_interface
`default_nettype wire

// ---- src/ebi_pkg.sv ----
// Constants and types of the external bus interface
package ebi_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_RDATA = 8'h0c;
    localparam logic [7:0] OFF_KEYS = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_FAULT = 8'h18;
    localparam logic [7:0] OFF_DISC = 8'h1c;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_GO = 0;
    localparam int CTRL_RD = 1;
    localparam int CTRL_MEM = 2;
    localparam int CTRL_DAT = 3;
    localparam int CTRL_LOCK = 4;
    localparam int DISC_DMA_ON = 0;
    localparam int DISC_DMA_OFF = 1;
    localparam int DISC_ST_OK = 2;
    localparam int DISC_ST_CLR = 3;
    localparam int DISC_ISTART = 4;
    localparam int FLT_PRT_OWN = 0;
    localparam int FLT_PRT_FOR = 1;
    localparam int FLT_PAR = 2;
    localparam int FLT_EXT_MEM = 5;
    localparam int FLT_EXT_IO = 8;
    localparam logic [15:0] FLT_MASK = 16'h0127;
    // ------------------------------------------------------------
    // Bus answers, addresses, timing
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [15:0] TRIG_ADDR = 16'h400b;
    localparam int CLK_NS = 8;
    localparam int TRIG_NS = 16;
    localparam logic [3:0] TRIG_CYC = 4'((TRIG_NS + CLK_NS - 1) / CLK_NS);
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_ADDR = 3'b010,
        ST_AHOLD = 3'b011,
        ST_DATA = 3'b100,
        ST_END = 3'b101
    } state_t;
    typedef struct packed {
        logic dat;
        logic rd;
        logic mem;
        logic lock;
    } cyc_t;
    typedef struct packed {
        logic dat;
        logic rd;
        logic mem;
    } status_t;
    typedef struct packed {
        logic [15:0] info;
        logic ext_n;
        logic par_n;
        logic prt_n;
        logic drdy;
        logic ardy;
        logic hold_n;
        logic busy_n;
        logic gnt_n;
    } sync_t;
    localparam sync_t SYNC_RST = 24'h0000e7;
endpackage : ebi_pkg

// ---- sim/bus_partner.sv ----
// Far-side model: memory or I/O slave with wait states
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
    input wire logic mclk_i,
    input wire logic address_strobe_i,
    input wire logic data_strobe_n_i,
    input wire logic [0:15] info_bus_i,
    input wire logic info_bus_oe_i,
    input wire logic [3:0] wait_i,
    output logic address_ready_in_o,
    output logic data_ready_in_o,
    output logic [0:15] info_bus_o,
    output logic [15:0] addr_o,
    output logic [15:0] wdata_o
);
    logic [3:0] cnt = 4'h0;
    logic [0:15] last = 16'h0000;
    always_ff @(posedge mclk_i) begin
        cnt <= (address_strobe_i || !data_strobe_n_i) ? cnt + 4'h1 : 4'h0;
        last <= info_bus_o;
    end
    // Ready held off for wait_i cycles of each phase
    assign address_ready_in_o = address_strobe_i && cnt >= wait_i;
    assign data_ready_in_o = !data_strobe_n_i && cnt >= wait_i;
    // Undriven bus toggles so a stale value never looks valid
    assign info_bus_o = (!data_strobe_n_i && !info_bus_oe_i) ? 16'hc3a5 : ~last;
    always_ff @(negedge address_strobe_i) addr_o <= info_bus_i;
    always_ff @(negedge mclk_i) if (!data_strobe_n_i && info_bus_oe_i) wdata_o <= info_bus_i;
endmodule : bus_partner
`default_nettype wire

// ---- sim/tb.sv ----
// Testbench: bus cycles, faults and discretes of the external bus interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
    import ebi_pkg::*;
    logic mclk_i = 1'b0, nrst_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, q;
    logic [3:0] s_axi_wstrb_i = 4'hf, wt = 4'h0, processor_state_o, page_group_select_o;
    logic bus_grant_n_i = 1'b0, fbusy = 1'b1, protect_fault_n_i = 1'b1, rq = 1'b0;
    logic parity_fault_n_i = 1'b1, ext_addr_fault_n_i = 1'b1, trg = 1'b0, ist = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
    status_t bus_status_o;
    logic address_strobe_o, data_strobe_n_o, ctl_oe_o, info_bus_oe_o, bus_request_n_o;
    logic bus_busy_n_o, bus_busy_oe_o, bus_hold_n_o, bus_hold_oe_o, dma_en_o, priv_ok_o;
    logic self_test_passed_o, instr_start_flag_o, trigger_pulse_n_o;
    logic address_ready_in_i, data_ready_in_i;
    logic [0:15] info_bus_o, pinfo;
    logic [15:0] paddr, pwdata;
    int miscompares = 0, n_checks = 0;
    wire [0:15] info_bus_i = info_bus_oe_o ? info_bus_o : pinfo;
    wire bus_busy_n_i = bus_busy_oe_o ? bus_busy_n_o : fbusy;
    wire bus_hold_n_i = bus_hold_oe_o ? bus_hold_n_o : fbusy;
    cpu_external_bus_interface dut (.*);
    bus_partner far (.mclk_i, .address_strobe_i(address_strobe_o), .wait_i(wt),
        .data_strobe_n_i(data_strobe_n_o), .info_bus_i(info_bus_o), .info_bus_oe_i(info_bus_oe_o),
        .address_ready_in_o(address_ready_in_i), .data_ready_in_o(data_ready_in_i),
        .info_bus_o(pinfo), .addr_o(paddr), .wdata_o(pwdata));
    always #4 mclk_i = ~mclk_i;
    // Short pulses are caught mid-cycle and kept until the test clears them
    always @(negedge mclk_i) begin
        if (bus_request_n_o === 1'b0) rq = 1'b1;
        if (trigger_pulse_n_o === 1'b0) trg = 1'b1;
        if (instr_start_flag_o === 1'b1) ist = 1'b1;
    end
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // Register port and bus cycle tasks
    // ------------------------------------------------------------
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] o, output logic [1:0] rs);
        logic ka, kw, kr, kb;
        int n;
        @(posedge mclk_i);
        n = 0;
        s_axi_awaddr_i <= a;
        s_axi_araddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= w;
        s_axi_wvalid_i <= w;
        s_axi_bready_i <= w;
        s_axi_arvalid_i <= !w;
        s_axi_rready_i <= !w;
        do begin
            @(negedge mclk_i);
            ka = s_axi_awready_o === 1'b1;
            kw = s_axi_wready_o === 1'b1;
            kr = s_axi_arready_o === 1'b1;
            kb = (w ? s_axi_bvalid_o : s_axi_rvalid_o) === 1'b1;
            o = s_axi_rdata_o;
            rs = w ? s_axi_bresp_o : s_axi_rresp_o;
            n++;
            @(posedge mclk_i);
            if (ka) s_axi_awvalid_i <= 1'b0;
            if (kw) s_axi_wvalid_i <= 1'b0;
            if (kr) s_axi_arvalid_i <= 1'b0;
        end while (!kb && n < 200);
        s_axi_bready_i <= 1'b0;
        s_axi_rready_i <= 1'b0;
        if (!kb) miscompares++;
    endtask : acc
    // lk: 0 unlocked, 1 locking, 2 cycle that ends a lock
    task automatic cyc(input logic [7:0] c, input logic [2:0] st, input logic [1:0] lk,
                       input logic [15:0] a);
        int n;
        n = 0;
        rq = 1'b0;
        if (c != 8'h00) acc(1'b1, OFF_CTRL, {24'h0, c}, q, r);
        while (address_strobe_o !== 1'b1 && n < 99) begin
            @(negedge mclk_i);
            n++;
        end
        `CHK("status", st, bus_status_o)
        `CHK("address out", a, info_bus_o)
        `CHK("request", 1'b1, bus_request_n_o)
        `CHK("owner drives", 1'b1, ctl_oe_o)
        `CHK("busy low", 1'b0, bus_busy_n_o)
        while (bus_busy_n_o !== 1'b1 && n < 99) begin
            if (lk == 2'd0) `CHK("hold", bus_busy_n_o, bus_hold_n_o)
            @(negedge mclk_i);
            n++;
        end
        `CHK("cycle ends", 1'b1, n < 99)
        repeat (3) @(negedge mclk_i);
        `CHK("hold after", lk != 2'd1, bus_hold_n_i)
        `CHK("latched addr", a, paddr)
        `CHK("requested", 1'b1, rq)
    endtask : cyc
    initial begin
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (4) @(negedge mclk_i);
        `CHK("init trigger", 1'b1, trg)
        `CHK("dma at reset", 1'b0, dma_en_o)
        `CHK("idle float", 3'b000, {ctl_oe_o, info_bus_oe_o, bus_busy_oe_o})
        acc(1'b1, OFF_KEYS, 32'h0000_00a5, q, r);
        `CHK("key", 4'h5, processor_state_o)
        `CHK("page group", 4'ha, page_group_select_o)
        `CHK("privileged", 1'b0, priv_ok_o)
        acc(1'b1, OFF_KEYS, 32'h0, q, r);
        `CHK("privileged", 1'b1, priv_ok_o)
        acc(1'b1, OFF_ADDR, 32'h1234, q, r);
        acc(1'b1, OFF_WDATA, 32'hbeef, q, r);
        @(posedge mclk_i);
        wt <= 4'h3;
        parity_fault_n_i <= 1'b0;
        protect_fault_n_i <= 1'b0;
        ext_addr_fault_n_i <= 1'b0;
        trg = 1'b0;
        cyc(8'h0d, 3'b101, 2'd0, 16'h1234);
        `CHK("write data", 16'hbeef, pwdata)
        `CHK("no trigger", 1'b0, trg)
        @(posedge mclk_i);
        parity_fault_n_i <= 1'b1;
        protect_fault_n_i <= 1'b1;
        acc(1'b0, OFF_FAULT, 32'h0, q, r);
        `CHK("own faults", 32'h25, q)
        `CHK("read resp", RESP_OKAY, r)
        acc(1'b1, OFF_FAULT, 32'hffff, q, r);
        acc(1'b1, OFF_ADDR, 32'h400b, q, r);
        cyc(8'h03, 3'b010, 2'd0, 16'h400b);
        `CHK("trigger", 1'b1, trg)
        acc(1'b0, OFF_RDATA, 32'h0, q, r);
        `CHK("read data", 32'hc3a5, q)
        acc(1'b0, OFF_FAULT, 32'h0, q, r);
        `CHK("io fault", 32'h100, q)
        @(posedge mclk_i);
        ext_addr_fault_n_i <= 1'b1;
        bus_grant_n_i <= 1'b1;
        acc(1'b1, OFF_FAULT, 32'hffff, q, r);
        acc(1'b1, OFF_CTRL, 32'h07, q, r);
        @(posedge mclk_i);
        fbusy <= 1'b0;
        protect_fault_n_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        fbusy <= 1'b1;
        repeat (8) @(posedge mclk_i);
        protect_fault_n_i <= 1'b1;
        @(negedge mclk_i);
        `CHK("grant high", 3'b000, {ctl_oe_o, info_bus_oe_o, bus_busy_oe_o})
        `CHK("waiting request", 1'b0, bus_request_n_o)
        @(posedge mclk_i);
        bus_grant_n_i <= 1'b0;
        cyc(8'h00, 3'b011, 2'd0, 16'h400b);
        acc(1'b0, OFF_FAULT, 32'h0, q, r);
        `CHK("foreign fault", 32'h002, q)
        cyc(8'h17, 3'b011, 2'd1, 16'h400b);
        cyc(8'h07, 3'b011, 2'd2, 16'h400b);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, OFF_DISC, 32'h1 << i, q, r);
            repeat (2) @(negedge mclk_i);
            `CHK("dma", i == 0, dma_en_o)
            `CHK("self test", i == 2, self_test_passed_o)
        end
        @(posedge mclk_i);
        ist = 1'b0;
        acc(1'b1, OFF_DISC, 32'h10, q, r);
        repeat (2) @(negedge mclk_i);
        `CHK("instr start", 1'b1, ist)
        acc(1'b1, 8'h20, 32'h0, q, r);
        `CHK("unmapped", RESP_SLVERR, r)
        results();
    end
    initial begin
        #200000;
        miscompares++;
        results();
    end
endmodule : tb
`default_nettype wire
